// ==== hdl/sscs_top.sv ====
// Purpose: Selects and conditions the switching main clock: internal with optional
//          spread-spectrum, or locked to an external sync clock with fallback.
// Assumes: One 40 MHz ref_clk times all logic; fuse inputs are stable after reset.
// Notes:   The analog clocks are modelled by phase accumulators on ref_clk.
// How it works
// - Spread modulation runs on the internal clock only when spread enable is set.
// - Spread enable and width take their fuse values once after reset.
// - Width select zero gives five percent peak deviation, one gives ten.
// - The triangle modulation repeats at 24 kHz on the internal clock.
// - External sync enabled with the sync fuse on forces spread off whatever spread enable says.
// - Fuse sync off keeps the PLL off and the internal clock always.
// - Fuse sync on keeps the PLL on, fed by internal or external clock.
// - Sync window is 2000-3000 kHz for band zero, 333-500 kHz for one.
// - Band select takes its fuse value once after reset.
// - A sync period outside the selected window, rounded outward to whole ref_clk cycles, counts as invalid.
// - Absent or invalid external clock falls back and raises the fault flag.
// - Fault state is one while the sync clock is missing or invalid.
// - External clock returns only after flag cleared and input valid.
// - Sync output disabled holds its pin low.
// - Sync output enabled toggles at the switching base frequency.
// - Sync output enable is host writable and loads its fuse value at start.
// - All control logic runs from the single block clock.
// - Internal switching clock is the high-frequency clock divided by eight.
// - Trim is ignored while spread or external sync is in use.
`timescale 1ns/1ps
module sscs_top
   import sscs_pkg::*;
(
   // Clock, reset and freeze.
   input  wire logic              ref_clk,
   input  wire logic              rst,
   input  wire logic              clk_en,
   // Fuse defaults, read once after reset.
   input  wire logic              spread_enable_fuse_default,
   input  wire logic              spread_width_fuse_default,
   input  wire logic              ext_sync_fuse_enable,
   input  wire logic              ext_clock_band_fuse_default,
   input  wire logic              sync_clock_out_fuse_default,
   // Host control writes.
   input  wire logic              host_wr,
   input  wire logic              host_spread_enable,
   input  wire logic              host_spread_width_select,
   input  wire logic              host_ext_sync_enable,
   input  wire logic              host_ext_clock_band_select,
   input  wire logic              host_sync_clock_out_enable,
   input  wire logic [TRIM_W-1:0] hf_clock_trim,
   input  wire logic              fault_flag_clear,
   input  wire logic              fault_mask,
   // External clock pin.
   input  wire logic              ext_clock_in,
   // Control readback.
   output logic                   spread_enable,
   output logic                   spread_width_select,
   output logic                   ext_sync_enable,
   output logic                   ext_clock_band_select,
   output logic                   sync_clock_out_enable,
   // Status.
   output logic                   pll_enable,
   output logic                   spread_active,
   output logic                   ext_clock_selected,
   output logic                   ext_clock_fault_flag,
   output logic                   ext_clock_fault_state,
   output logic                   interrupt_out_n,
   // Clock outputs.
   output logic                   sw_clock_out,
   output logic                   sync_clock_out
);

   sscs_src_e               src_r;
   sscs_src_e               src_nxt;
   logic                    fuse_sync_r;
   logic                    spread_en_r;
   logic                    width_r;
   logic                    sync_en_r;
   logic                    band_r;
   logic                    out_en_r;
   logic                    flag_r;
   logic                    state_r;
   logic                    irq_n_r;
   logic                    spread_act_r;
   logic                    sync_eff;
   logic                    ext_valid;
   logic                    ext_level;
   logic [ACC_W-1:0]        acc_r;
   logic [ACC_W-1:0]        inc_r;
   logic [ACC_W-1:0]        inc_nxt;
   logic                    hf_tick_r;
   logic [DIV_W-1:0]        div_r;
   logic                    sw_r;
   logic                    sync_out_r;
   logic [STEP_W-1:0]       step_r;
   logic signed [7:0]       tri_r;
   logic                    tri_up_r;

   // Maps a trim code to its accumulator step; unused codes fall back to nominal.
   function automatic logic [ACC_W-1:0] trim_inc(input logic [TRIM_W-1:0] code);
      longint mhz;
      mhz = TRIM_BASE_HI_MHZ;
      if (code <= TRIM_HI_LAST)
         mhz = TRIM_BASE_HI_MHZ + longint'(code);
      else if (code >= TRIM_LO_FIRST && code <= TRIM_LO_LAST)
         mhz = TRIM_BASE_LO_MHZ + longint'(code - TRIM_LO_FIRST);
      trim_inc = ACC_W'((mhz << ACC_W) / REF_MHZ);
   endfunction

   // External sync is only in force when the fuse allows it.
   assign sync_eff = fuse_sync_r & sync_en_r;

   sscs_freq_check u_check (
      .ref_clk      (ref_clk),
      .rst          (rst),
      .clk_en       (clk_en),
      .enable       (sync_eff),
      .band_sel     (band_r),
      .ext_clock_in (ext_clock_in),
      .valid_r      (ext_valid),
      .level_r      (ext_level)
   );

   // Control bits load from fuses in the load state, then follow host writes.
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         fuse_sync_r <= 1'b0;
         spread_en_r <= 1'b0;
         width_r     <= 1'b0;
         sync_en_r   <= 1'b0;
         band_r      <= 1'b0;
         out_en_r    <= 1'b0;
      end
      else if (clk_en)
      begin
         if (src_r == SSCS_LOAD)
         begin
            fuse_sync_r <= ext_sync_fuse_enable;
            spread_en_r <= spread_enable_fuse_default;
            width_r     <= spread_width_fuse_default;
            sync_en_r   <= ext_sync_fuse_enable;
            band_r      <= ext_clock_band_fuse_default;
            out_en_r    <= sync_clock_out_fuse_default;
         end
         else if (host_wr)
         begin
            spread_en_r <= host_spread_enable;
            width_r     <= host_spread_width_select;
            sync_en_r   <= host_ext_sync_enable;
            band_r      <= host_ext_clock_band_select;
            out_en_r    <= host_sync_clock_out_enable;
         end
      end
   end

   // Source selection; a fallback waits for both a cleared flag and a valid input.
   always_comb
   begin
      src_nxt = src_r;
      unique case (src_r)
         SSCS_LOAD:
            src_nxt = SSCS_INTERNAL;
         SSCS_INTERNAL:
            if (sync_eff && ext_valid && !flag_r)
               src_nxt = SSCS_EXTERNAL;
         SSCS_EXTERNAL:
            if (!sync_eff)
               src_nxt = SSCS_INTERNAL;
            else if (!ext_valid)
               src_nxt = SSCS_FALLBACK;
         SSCS_FALLBACK:
            if (!sync_eff)
               src_nxt = SSCS_INTERNAL;
            else if (ext_valid && !flag_r)
               src_nxt = SSCS_EXTERNAL;
      endcase
   end

   // Source state register.
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         src_r <= SSCS_LOAD;
      else if (clk_en)
         src_r <= src_nxt;
   end

   // Sticky fault flag; a new fault in the clear cycle wins over the clear.
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         flag_r <= 1'b0;
      else if (clk_en)
      begin
         if (src_r == SSCS_EXTERNAL && sync_eff && !ext_valid)
            flag_r <= 1'b1;
         else if (fault_flag_clear)
            flag_r <= 1'b0;
      end
   end

   // Live fault state and the masked active-low interrupt.
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         state_r <= 1'b0;
         irq_n_r <= 1'b1;
      end
      else if (clk_en)
      begin
         state_r <= sync_eff & ~ext_valid;
         irq_n_r <= ~(flag_r & ~fault_mask);
      end
   end

   // Spread runs only when enabled and external sync is not in force.
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         spread_act_r <= 1'b0;
      else if (clk_en)
         spread_act_r <= spread_en_r & ~sync_eff & (src_r != SSCS_LOAD);
   end

   // Triangle generator; a fractional step timer keeps the sweep at 24 kHz, not a rounded rate.
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         step_r   <= '0;
         tri_r    <= '0;
         tri_up_r <= 1'b1;
      end
      else if (clk_en)
      begin
         if (!spread_act_r)
         begin
            step_r   <= '0;
            tri_r    <= '0;
            tri_up_r <= 1'b1;
         end
         else if (step_r >= MOD_STEP_WRAP - MOD_STEP_INC)
         begin
            step_r <= step_r + MOD_STEP_INC - MOD_STEP_WRAP;
            if (tri_up_r)
            begin
               tri_r    <= tri_r + 8'sd1;
               tri_up_r <= (tri_r != 8'(TRI_PEAK - 1));
            end
            else
            begin
               tri_r    <= tri_r - 8'sd1;
               tri_up_r <= (tri_r == 8'(1 - TRI_PEAK));
            end
         end
         else
            step_r <= step_r + MOD_STEP_INC;
      end
   end

   // Frequency step: spread around nominal, nominal under external sync, else trim; trim never mixes with spread.
   always_comb
   begin
      logic signed [63:0] dev;
      dev = 64'sd0;
      if (spread_act_r)
      begin
         dev = $signed({32'd0, (width_r ? DEV_WIDE : DEV_NARROW)}) * 64'(tri_r);
         inc_nxt = ACC_W'((64'(HF_INC_NOM) + (dev >>> TRI_SHIFT)));
      end
      else if (sync_eff)
         inc_nxt = HF_INC_NOM;
      else
         inc_nxt = trim_inc(hf_clock_trim);
   end

   // High-frequency phase accumulator; its carry is one high-frequency clock edge.
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         inc_r     <= HF_INC_NOM;
         acc_r     <= '0;
         hf_tick_r <= 1'b0;
      end
      else if (clk_en)
      begin
         inc_r                <= inc_nxt;
         {hf_tick_r, acc_r}   <= {1'b0, acc_r} + {1'b0, inc_r};
      end
   end

   // Divide-by-eight counter; the internal switching clock is its top bit.
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         div_r <= '0;
      else if (clk_en && hf_tick_r)
         div_r <= div_r + DIV_W'(1);
   end

   // Switching clock source and the sync output; a disabled output is held low.
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         sw_r       <= 1'b0;
         sync_out_r <= 1'b0;
      end
      else if (clk_en)
      begin
         sw_r       <= (src_r == SSCS_EXTERNAL) ? ext_level : div_r[DIV_W-1];
         sync_out_r <= out_en_r & sw_r;
      end
   end

   // Registered outputs.
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         pll_enable         <= 1'b0;
         ext_clock_selected <= 1'b0;
      end
      else if (clk_en)
      begin
         pll_enable         <= fuse_sync_r;
         ext_clock_selected <= (src_nxt == SSCS_EXTERNAL);
      end
   end

   assign spread_enable         = spread_en_r;
   assign spread_width_select   = width_r;
   assign ext_sync_enable       = sync_en_r;
   assign ext_clock_band_select = band_r;
   assign sync_clock_out_enable = out_en_r;
   assign spread_active         = spread_act_r;
   assign ext_clock_fault_flag  = flag_r;
   assign ext_clock_fault_state = state_r;
   assign interrupt_out_n       = irq_n_r;
   assign sw_clock_out          = sw_r;
   assign sync_clock_out        = sync_out_r;

endmodule

// ==== inc/sscs_pkg.sv ====
// Purpose: Shared constants for the switching clock spread and sync block.
// Assumes: ref_clk runs at 40 MHz; all phase figures are 32-bit accumulator steps.
// Notes:   Cycle counts are derived from the printed frequencies, never typed in.
package sscs_pkg;

   // Reference clock and accumulator width.
   localparam longint REF_HZ      = 40_000_000;
   localparam int     ACC_W       = 32;

   // Internal high-frequency clock and its divider to the switching clock.
   localparam longint HF_NOM_HZ   = 20_000_000;
   localparam int     SW_DIV      = 8;
   localparam int     DIV_W       = 3;
   localparam logic [ACC_W-1:0] HF_INC_NOM =
      ACC_W'((HF_NOM_HZ << ACC_W) / REF_HZ);

   // Spread modulation: 4 x TRI_PEAK steps per period, timed by a fractional step sum.
   localparam longint MOD_HZ      = 24_000;
   localparam int     TRI_PEAK    = 64;
   localparam int     TRI_SHIFT   = 6;
   localparam int     TRI_STEPS   = 4 * TRI_PEAK;
   localparam int     STEP_W      = 26;
   localparam logic [STEP_W-1:0] MOD_STEP_INC  = STEP_W'(MOD_HZ * TRI_STEPS);
   localparam logic [STEP_W-1:0] MOD_STEP_WRAP = STEP_W'(REF_HZ);
   localparam int     DEV_NARROW_PCT = 5;
   localparam int     DEV_WIDE_PCT   = 10;
   localparam logic [ACC_W-1:0] DEV_NARROW =
      ACC_W'((longint'(HF_INC_NOM) * DEV_NARROW_PCT) / 100);
   localparam logic [ACC_W-1:0] DEV_WIDE =
      ACC_W'((longint'(HF_INC_NOM) * DEV_WIDE_PCT) / 100);

   // Accepted sync input windows in kHz, per band select value.
   localparam longint BAND0_MIN_KHZ = 2000;
   localparam longint BAND0_MAX_KHZ = 3000;
   localparam longint BAND1_MIN_KHZ = 333;
   localparam longint BAND1_MAX_KHZ = 500;
   localparam int     PER_W         = 8;
   // Shortest legal period rounds down, longest rounds up, in ref_clk cycles.
   localparam logic [PER_W-1:0] BAND0_PER_MIN =
      PER_W'(REF_HZ / (BAND0_MAX_KHZ * 1000));
   localparam logic [PER_W-1:0] BAND0_PER_MAX =
      PER_W'((REF_HZ + BAND0_MIN_KHZ * 1000 - 1) / (BAND0_MIN_KHZ * 1000));
   localparam logic [PER_W-1:0] BAND1_PER_MIN =
      PER_W'(REF_HZ / (BAND1_MAX_KHZ * 1000));
   localparam logic [PER_W-1:0] BAND1_PER_MAX =
      PER_W'((REF_HZ + BAND1_MIN_KHZ * 1000 - 1) / (BAND1_MIN_KHZ * 1000));

   // Trim code width and the trim table bounds in MHz.
   localparam int     TRIM_W      = 4;
   localparam longint TRIM_BASE_HI_MHZ = 20;
   localparam longint TRIM_BASE_LO_MHZ = 16;
   localparam longint REF_MHZ     = 40;
   localparam logic [TRIM_W-1:0] TRIM_HI_LAST = 4'h4;
   localparam logic [TRIM_W-1:0] TRIM_LO_FIRST = 4'h9;
   localparam logic [TRIM_W-1:0] TRIM_LO_LAST = 4'hC;

   // Clock source state machine, Gray coded along load, internal, external, fallback.
   typedef enum logic [1:0] {
      SSCS_LOAD     = 2'b00,
      SSCS_INTERNAL = 2'b01,
      SSCS_EXTERNAL = 2'b11,
      SSCS_FALLBACK = 2'b10
   } sscs_src_e;

endpackage

// ==== hdl/sscs_freq_check.sv ====
// Purpose: Judges whether the external sync clock lies in the selected window.
// Assumes: ext_clock_in is synchronous to ref_clk.
// Notes:   A period is the count of ref_clk cycles between two rising edges.
`timescale 1ns/1ps
module sscs_freq_check
   import sscs_pkg::*;
(
   // Clock, reset and enable.
   input  wire logic ref_clk,
   input  wire logic rst,
   input  wire logic clk_en,
   // Measurement control.
   input  wire logic enable,
   input  wire logic band_sel,
   input  wire logic ext_clock_in,
   // Results.
   output logic      valid_r,
   output logic      level_r
);

   logic             prev_r;
   logic [PER_W-1:0] cnt_r;
   logic [PER_W-1:0] per_min;
   logic [PER_W-1:0] per_max;
   logic             rise;

   // Window limits follow the band select bit.
   assign per_min = band_sel ? BAND1_PER_MIN : BAND0_PER_MIN;
   assign per_max = band_sel ? BAND1_PER_MAX : BAND0_PER_MAX;
   assign rise    = level_r & ~prev_r;

   // Sample the pin and keep the previous sample for edge detection.
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         level_r <= 1'b0;
         prev_r  <= 1'b0;
      end
      else if (clk_en)
      begin
         level_r <= ext_clock_in;
         prev_r  <= level_r;
      end
   end

   // Counter rests saturated: a first edge after enable or a stopped clock is out of range.
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         cnt_r <= '1;
      else if (clk_en)
      begin
         if (!enable)
            cnt_r <= '1;
         else if (rise)
            cnt_r <= PER_W'(1);
         else if (cnt_r != '1)
            cnt_r <= cnt_r + PER_W'(1);
      end
   end

   // Each measured period decides validity; a missing edge past the limit is absent.
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         valid_r <= 1'b0;
      else if (clk_en)
      begin
         if (!enable)
            valid_r <= 1'b0;
         else if (rise)
            valid_r <= (cnt_r >= per_min) && (cnt_r <= per_max);
         else if (cnt_r > per_max)
            valid_r <= 1'b0;
      end
   end

endmodule

// ==== test/sscs_ext_src.sv ====
// Purpose: Behavioural external sync clock source for the bench.
// Assumes: The source is timed by ref_clk, so its edges land just after a ref_clk edge.
// Notes:   When stopped the pin sits low, as the pulled-down idle line would.
`timescale 1ns/1ps
module sscs_ext_src
(
   // Clock and control.
   input  wire logic       ref_clk,
   input  wire logic       run,
   input  wire logic [7:0] per,
   // Sync pin.
   output logic            ext_clock_in
);
   int cnt;

   // Square wave of per cycles, high for the first half, so the duty stays at 50 percent.
   always @(posedge ref_clk)
   begin
      if (!run)
      begin
         cnt          <= 0;
         ext_clock_in <= 1'b0;
      end
      else
      begin
         cnt          <= (cnt + 1 >= int'(per)) ? 0 : cnt + 1;
         ext_clock_in <= (cnt < int'(per) / 2);
      end
   end
endmodule

// ==== test/sscs_top_monitor.sv ====
// Purpose: Watches the clock block ports for the relations it must keep.
// Assumes: One clock domain, reset asynchronous and active high.
// Notes:   Idle bounds leave slack for the pin sampling pipeline.
`timescale 1ns/1ps
module sscs_top_monitor
(
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rst,
   // Watched inputs.
   input wire logic spread_enable_fuse_default,
   input wire logic spread_width_fuse_default,
   input wire logic ext_clock_band_fuse_default,
   input wire logic fault_mask,
   input wire logic ext_clock_in,
   // Watched outputs.
   input wire logic spread_enable,
   input wire logic spread_width_select,
   input wire logic ext_sync_enable,
   input wire logic ext_clock_band_select,
   input wire logic sync_clock_out_enable,
   input wire logic pll_enable,
   input wire logic spread_active,
   input wire logic ext_clock_selected,
   input wire logic ext_clock_fault_flag,
   input wire logic interrupt_out_n,
   input wire logic sw_clock_out,
   input wire logic sync_clock_out
);
   logic       pin_r;
   logic [7:0] idle_r;

   // Cycles since the sync pin last moved; it saturates so a dead pin never wraps.
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         pin_r  <= 1'b0;
         idle_r <= 8'h00;
      end
      else
      begin
         pin_r  <= ext_clock_in;
         idle_r <= (ext_clock_in != pin_r) ? 8'h00 : idle_r + 8'(idle_r != 8'hFF);
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   // Steps of the fuse load and of the fault report.
   sequence s_fuse_edge;
      $fell(rst);
   endsequence
   sequence s_fuse_seen;
      spread_enable == spread_enable_fuse_default &&
      spread_width_select == spread_width_fuse_default &&
      ext_clock_band_select == ext_clock_band_fuse_default;
   endsequence
   sequence s_flag_open;
      ext_clock_fault_flag && !fault_mask;
   endsequence

   a_fuse_load: assert property (s_fuse_edge |=> s_fuse_seen)
      else $error("control bits differ from fuses");
   a_spread_run: assert property
      ((spread_enable && !(ext_sync_enable && pll_enable))[*3] |-> spread_active)
      else $error("spread not running while enabled");
   a_spread_off: assert property ((!spread_enable)[*3] |-> !spread_active)
      else $error("spread running while disabled");
   a_sync_kills: assert property ((ext_sync_enable && pll_enable)[*3] |-> !spread_active)
      else $error("spread running while sync is enabled");
   a_pll_gate: assert property (!pll_enable |-> !ext_clock_selected)
      else $error("external clock used with pll off");
   a_out_low: assert property ((!sync_clock_out_enable)[*2] |-> !sync_clock_out)
      else $error("sync output moves while disabled");
   a_out_follow: assert property (sync_clock_out_enable && $past(sync_clock_out_enable)
      |-> sync_clock_out == $past(sw_clock_out))
      else $error("sync output not repeating switch clock");
   a_fault_drop: assert property ($rose(ext_clock_fault_flag)
      |-> !ext_clock_selected && $past(ext_clock_selected))
      else $error("fault flag without fallback");
   a_irq_low: assert property (s_flag_open |=> !interrupt_out_n)
      else $error("interrupt missing for open fault");
   a_irq_quiet: assert property ((!ext_clock_fault_flag || fault_mask) |=> interrupt_out_n)
      else $error("interrupt without open fault");
   a_hold_int: assert property (ext_clock_fault_flag |-> !ext_clock_selected)
      else $error("external clock used while flagged");
   a_band0_lost: assert property
      (!ext_clock_band_select && idle_r > 8'h1E |-> !ext_clock_selected)
      else $error("dead pin selected, fast band");
   a_band1_lost: assert property (idle_r > 8'h87 |-> !ext_clock_selected)
      else $error("dead pin selected, slow band");
endmodule

bind sscs_top sscs_top_monitor u_mon (.*);

// ==== test/tb_switching_clock_spread_sync.sv ====
// Purpose: Self-checking bench for the switching clock spread and sync block.
// Assumes: 40 MHz ref_clk; clk_en held high throughout.
// Notes:   Edge counts allow a little slack for where the count window starts.
`timescale 1ns/1ps
module tb_switching_clock_spread_sync
   import sscs_pkg::*;
;
   typedef struct packed {logic [4:0] v; logic sa; logic tog;} sscs_row_s;

   logic ref_clk = 1'b0, rst = 1'b1, clk_en = 1'b1, host_wr = 1'b0;
   logic spread_enable_fuse_default = 1'b1, spread_width_fuse_default = 1'b0;
   logic ext_sync_fuse_enable = 1'b1, ext_clock_band_fuse_default = 1'b0;
   logic sync_clock_out_fuse_default = 1'b1, fault_flag_clear = 1'b0, fault_mask = 1'b0;
   logic host_spread_enable = 1'b0, host_spread_width_select = 1'b0;
   logic host_ext_sync_enable = 1'b0, host_ext_clock_band_select = 1'b0;
   logic host_sync_clock_out_enable = 1'b0, src_run = 1'b0, ext_clock_in;
   logic [TRIM_W-1:0] hf_clock_trim = 4'h0;
   logic [7:0]        src_per = 8'h10;
   logic spread_enable, spread_width_select, ext_sync_enable, ext_clock_band_select;
   logic sync_clock_out_enable, pll_enable, spread_active, ext_clock_selected;
   logic ext_clock_fault_flag, ext_clock_fault_state, interrupt_out_n;
   logic sw_clock_out, sync_clock_out;
   int   n_errors = 0, num_checks = 0, n;
   wire logic [4:0] rb = {spread_enable, spread_width_select, ext_sync_enable,
                          ext_clock_band_select, sync_clock_out_enable};
   wire logic [4:0] fz = {spread_enable_fuse_default, spread_width_fuse_default,
                          ext_sync_fuse_enable, ext_clock_band_fuse_default,
                          sync_clock_out_fuse_default};
   // Ordinary cases: written control bits, expected spread state and output activity.
   sscs_row_s rows [5] = '{'{5'b10000, 1'b1, 1'b0}, '{5'b11001, 1'b1, 1'b1},
                           '{5'b10101, 1'b0, 1'b1}, '{5'b00001, 1'b0, 1'b1},
                           '{5'b01000, 1'b0, 1'b0}};

   sscs_top u_dut (.*);
   sscs_ext_src u_src (.ref_clk(ref_clk), .run(src_run), .per(src_per),
                       .ext_clock_in(ext_clock_in));

   // Half period of 12.5 ns gives the 40 MHz clock.
   always #12.5 ref_clk = ~ref_clk;

   // Comparison, wait and host write helpers.
   task automatic chk(input logic got, input logic exp, input string m);
      num_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[FAIL] %0t %s got %b", $time, m, got);
      end
   endtask
   task automatic chk_n(input int got, input int lo, input int hi, input string m);
      num_checks++;
      if (got < lo || got > hi)
      begin
         n_errors++;
         $display("[FAIL] %0t %s count %0d", $time, m, got);
      end
   endtask
   task automatic cyc(input int c);
      repeat (c) @(posedge ref_clk);
      #1;
   endtask
   task automatic wr(input logic [4:0] v);
      @(posedge ref_clk);
      host_wr <= 1'b1;
      {host_spread_enable, host_spread_width_select, host_ext_sync_enable,
       host_ext_clock_band_select, host_sync_clock_out_enable} <= v;
      @(posedge ref_clk);
      host_wr <= 1'b0;
      #1;
   endtask
   task automatic clr;
      @(posedge ref_clk) fault_flag_clear <= 1'b1;
      @(posedge ref_clk) fault_flag_clear <= 1'b0;
      cyc(3);
   endtask
   // Counts rising edges; values are read before the edge's own updates land.
   task automatic cnt_edges(input logic sel, input int c, output int k);
      logic prev;
      logic cur;
      k = 0;
      prev = 1'b1;
      repeat (c)
      begin
         @(posedge ref_clk);
         cur = sel ? sync_clock_out : sw_clock_out;
         if (cur === 1'b1 && prev === 1'b0)
            k++;
         prev = cur;
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // A hang is cut short well past the few thousand cycles the tests need.
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      n_errors++;
      $display("[FAIL] %0t watchdog expired", $time);
      report_and_stop;
   end

   // Main sequence.
   initial
   begin
      repeat (8) @(posedge ref_clk);
      rst <= 1'b0;
      cyc(3);
      chk(rb === fz, 1'b1, "fuse load");
      chk(pll_enable, 1'b1, "pll");
      chk(spread_active, 1'b0, "spread with sync");
      chk(interrupt_out_n, 1'b1, "idle irq");
      @(posedge ref_clk) src_run <= 1'b1;
      cyc(100);
      chk(ext_clock_selected, 1'b1, "ext lock");
      chk(ext_clock_fault_state, 1'b0, "ext state");
      cnt_edges(1'b0, 400, n);
      chk_n(n, 24, 26, "ext freq");
      $display("test startup done");
      foreach (rows[i])
      begin
         wr(rows[i].v);
         cyc(4);
         chk(rb === rows[i].v, 1'b1, "readback");
         chk(spread_active, rows[i].sa, "spread");
         cnt_edges(1'b1, 64, n);
         chk(n > 0, rows[i].tog, "sync out");
      end
      $display("test rows done");
      wr(5'b00000);
      cyc(20);
      cnt_edges(1'b0, 400, n);
      chk_n(n, 24, 26, "div8 nominal");
      @(posedge ref_clk) hf_clock_trim <= 4'h4;
      cyc(20);
      cnt_edges(1'b0, 400, n);
      chk_n(n, 29, 31, "div8 trimmed");
      wr(5'b10000);
      cyc(20);
      cnt_edges(1'b0, 1536, n);
      chk_n(n, 94, 98, "spread ignores trim");
      @(posedge ref_clk) hf_clock_trim <= 4'h0;
      $display("test internal done");
      wr(5'b00101);
      cyc(100);
      chk(ext_clock_selected, 1'b1, "relock");
      @(posedge ref_clk) src_run <= 1'b0;
      cyc(40);
      chk(ext_clock_fault_flag, 1'b1, "flag");
      chk(ext_clock_selected, 1'b0, "fallback");
      chk(ext_clock_fault_state, 1'b1, "state lost");
      chk(interrupt_out_n, 1'b0, "irq");
      @(posedge ref_clk) src_run <= 1'b1;
      cyc(80);
      chk(ext_clock_fault_state, 1'b0, "state back");
      chk(ext_clock_selected, 1'b0, "held internal");
      @(posedge ref_clk) fault_mask <= 1'b1;
      cyc(3);
      chk(interrupt_out_n, 1'b1, "masked irq");
      clr;
      chk(ext_clock_fault_flag, 1'b0, "flag cleared");
      chk(ext_clock_selected, 1'b1, "switch back");
      @(posedge ref_clk) src_per <= 8'h0C;
      cyc(80);
      chk(ext_clock_selected, 1'b0, "too fast");
      chk(ext_clock_fault_state, 1'b1, "too fast state");
      wr(5'b00111);
      @(posedge ref_clk) src_per <= 8'h64;
      cyc(400);
      chk(ext_clock_fault_state, 1'b0, "slow band");
      clr;
      chk(ext_clock_selected, 1'b1, "slow band lock");
      @(posedge ref_clk) fault_mask <= 1'b0;
      $display("test sync done");
      @(posedge ref_clk) rst <= 1'b1;
      ext_sync_fuse_enable <= 1'b0;
      src_per <= 8'h10;
      cyc(4);
      @(posedge ref_clk) rst <= 1'b0;
      cyc(3);
      wr(5'b00101);
      cyc(100);
      chk(pll_enable, 1'b0, "pll fused off");
      chk(ext_clock_selected, 1'b0, "internal only");
      $display("test fuse off done");
      report_and_stop;
   end
endmodule
